/* File: rtl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int CTRL_BITS        = 8;
	localparam int RESULT_BITS      = 12;
	localparam int OVERLAP_BIT      = 6;
	localparam int FRAME_CLOCKS     = 16;
	localparam int BIT_START        = 7;
	localparam int BIT_CH_MSB       = 6;
	localparam int BIT_CH_LSB       = 4;
	localparam int BIT_POLARITY     = 3;
	localparam int BIT_INPUT_CFG    = 2;
	localparam int BIT_PD_HI        = 1;
	localparam int BIT_PD_LO        = 0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int WAKE_TIME_NS     = 2000;
	localparam int WAKE_CYCLES      = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_TIME_NS    = 10000;
	localparam int RESET_CYCLES     = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Power modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		PM_FULL_POWER_DOWN = 2'h0,
		PM_FAST_POWER_DOWN = 2'h1,
		PM_REDUCED_POWER   = 2'h2,
		PM_NORMAL          = 2'h3
	} power_mode_t;
	localparam power_mode_t POWER_MODE_RESET = PM_NORMAL;

	typedef struct packed {
		logic [2:0]  channel;
		logic        polarity_select;
		logic        input_config_select;
		power_mode_t power_mode;
	} ctrl_byte_t;

	typedef struct packed {
		logic        converting;
		logic        hw_shutdown;
		logic        powered_up;
		power_mode_t power_state;
	} power_status_t;

endpackage

/* File: rtl/adc_serial_framing_power_ctrl.sv */
`timescale 1ns/1ps

module adc_serial_framing_power_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int WAKE_COUNT = WAKE_CYCLES
)(
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic                       serial_clk,
	input  wire logic                       chip_select_n,
	input  wire logic                       serial_in,
	input  wire logic                       hard_shutdown_n,
	input  wire logic [RESULT_BITS-1:0]     sample_value,
	output logic                            serial_out,
	output logic                            serial_out_oe,
	output logic                            conversion_strobe,
	output logic                            conversion_strobe_oe,
	output ctrl_byte_t                      active_ctrl,
	output adc_ctrl_pkg::power_status_t     power_status
);
	import adc_ctrl_pkg::*;

	// ----------------------------------------
	// Link domain: shutdown into serial clock domain
	// ----------------------------------------
	// Shutdown reset clears the link side asynchronously; release is synchronised.
	logic sd_meta_q;
	logic sd_sync_q;
	always_ff @(posedge serial_clk or negedge hard_shutdown_n or negedge reset_n) begin
		if (!reset_n || !hard_shutdown_n) begin
			sd_meta_q <= 1'b0;
			sd_sync_q <= 1'b0;
		end else begin
			sd_meta_q <= 1'b1;
			sd_sync_q <= sd_meta_q;
		end
	end
	wire link_rst_n = sd_sync_q;

	// ----------------------------------------
	// Link domain: control byte capture (rising edge)
	// ----------------------------------------
	typedef enum logic [1:0] {
		S_HUNT,
		S_CTRL,
		S_CONV
	} link_state_t;

	link_state_t     state_q;
	logic [2:0]      ctrl_cnt_q;
	logic [6:0]      ctrl_sr_q;
	logic [4:0]      out_cnt_q;
	logic            byte_done_q;
	logic            conv_q;
	logic            overlap_ok;
	logic [7:0]      full_byte;

	assign full_byte  = {1'b1, ctrl_sr_q};
	// A new start may only follow once result bit 6 is on the line;
	// bit 6 leaves on the falling edge that drops the count to six
	assign overlap_ok = (out_cnt_q <= 5'(OVERLAP_BIT));

	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_q     <= S_HUNT;
			ctrl_cnt_q  <= 3'h0;
			ctrl_sr_q   <= 7'h00;
			byte_done_q <= 1'b0;
		end else begin
			byte_done_q <= 1'b0;
			unique case (state_q)
				S_HUNT: begin
					// Chip select alone never starts; a high bit does
					if (!chip_select_n && serial_in) begin
						state_q    <= S_CTRL;
						ctrl_cnt_q <= 3'h1;
					end
				end
				S_CTRL: begin
					// Every bit is data until eight are in
					ctrl_sr_q  <= {ctrl_sr_q[5:0], serial_in};
					ctrl_cnt_q <= ctrl_cnt_q + 3'h1;
					if (ctrl_cnt_q == 3'(CTRL_BITS - 1)) begin
						state_q     <= S_CONV;
						byte_done_q <= 1'b1;
					end
				end
				S_CONV: begin
					// Serial activity cannot cancel; only shutdown or reset_n resets this domain
					if (overlap_ok && !chip_select_n && serial_in) begin
						state_q    <= S_CTRL;
						ctrl_cnt_q <= 3'h1;
					end else if (out_cnt_q == 5'h0 && !conv_q) begin
						state_q <= S_HUNT;
					end
				end
				default: state_q <= S_HUNT;
			endcase
		end
	end

	// ----------------------------------------
	// Link domain: conversion and output (falling edge)
	// ----------------------------------------
	logic                   strobe_q;
	logic [4:0]             out_cnt_q_n;
	logic [RESULT_BITS-1:0] result_q;
	logic                   dout_q;
	logic                   done_tgl_q;
	logic                   start_tgl_q;
	ctrl_byte_t             latched_q;

	always_ff @(negedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			conv_q      <= 1'b0;
			strobe_q    <= 1'b0;
			out_cnt_q_n <= 5'h0;
			result_q    <= '0;
			dout_q      <= 1'b0;
			done_tgl_q  <= 1'b0;
			start_tgl_q <= 1'b0;
			latched_q   <= '{3'h0, 1'b0, 1'b0, POWER_MODE_RESET};
		end else if (byte_done_q) begin
			// Launch on the falling edge after the last control bit
			conv_q      <= 1'b1;
			strobe_q    <= 1'b1;
			out_cnt_q_n <= 5'(RESULT_BITS);
			result_q    <= sample_value;
			dout_q      <= 1'b0;
			start_tgl_q <= ~start_tgl_q;
			latched_q   <= '{full_byte[BIT_CH_MSB:BIT_CH_LSB], full_byte[BIT_POLARITY],
				full_byte[BIT_INPUT_CFG], power_mode_t'(full_byte[BIT_PD_HI:BIT_PD_LO])};
		end else begin
			strobe_q <= 1'b0;
			if (out_cnt_q_n != 5'h0) begin
				dout_q      <= result_q[RESULT_BITS-1];
				result_q    <= {result_q[RESULT_BITS-2:0], 1'b0};
				out_cnt_q_n <= out_cnt_q_n - 5'h1;
				if (out_cnt_q_n == 5'h1) begin
					conv_q     <= 1'b0;
					done_tgl_q <= ~done_tgl_q;
				end
			end else begin
				dout_q <= 1'b0;
			end
		end
	end
	assign out_cnt_q = out_cnt_q_n;

	// Pins float whenever chip select is high
	assign serial_out           = dout_q;
	assign serial_out_oe        = !chip_select_n;
	assign conversion_strobe    = strobe_q;
	assign conversion_strobe_oe = !chip_select_n;

	// ----------------------------------------
	// System domain: crossings
	// ----------------------------------------
	logic [2:0] done_s_q;
	logic [2:0] start_s_q;
	logic [1:0] sd_s_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			done_s_q  <= 3'h0;
			start_s_q <= 3'h0;
			// Idle level of the pin, so no false shutdown follows reset
			sd_s_q    <= 2'h3;
		end else begin
			done_s_q  <= {done_s_q[1:0], done_tgl_q};
			start_s_q <= {start_s_q[1:0], start_tgl_q};
			sd_s_q    <= {sd_s_q[0], hard_shutdown_n};
		end
	end
	wire done_evt  = done_s_q[2] ^ done_s_q[1];
	wire start_evt = start_s_q[2] ^ start_s_q[1];
	wire sd_n      = sd_s_q[1];

	// ----------------------------------------
	// System domain: power sequencing
	// ----------------------------------------
	power_mode_t pend_mode_q;
	power_status_t st_q;
	logic [$clog2(WAKE_COUNT+1)-1:0] wake_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_mode_q <= POWER_MODE_RESET;
			st_q        <= '{1'b0, 1'b0, 1'b0, POWER_MODE_RESET};
			wake_q      <= '0;
		end else if (!sd_n) begin
			// Shutdown wins over any software mode and ends the conversion
			st_q.hw_shutdown <= 1'b1;
			// Release always wakes into full power, whatever mode was programmed
			st_q.power_state <= PM_NORMAL;
			st_q.converting  <= 1'b0;
			st_q.powered_up  <= 1'b0;
			wake_q           <= '0;
		end else begin
			st_q.hw_shutdown <= 1'b0;
			if (start_evt) begin
				// Every section at full power while converting
				st_q.converting  <= 1'b1;
				st_q.power_state <= PM_NORMAL;
				pend_mode_q      <= latched_q.power_mode;
			end else if (done_evt) begin
				st_q.converting  <= 1'b0;
				st_q.power_state <= pend_mode_q;
			end
			// Wake timer restarts whenever full power-down is being left
			if (st_q.power_state == PM_FULL_POWER_DOWN && !st_q.converting) begin
				wake_q          <= '0;
				st_q.powered_up <= 1'b0;
			end else if (wake_q != WAKE_COUNT[$bits(wake_q)-1:0]) begin
				wake_q <= wake_q + 1'b1;
			end else begin
				st_q.powered_up <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			active_ctrl <= '{3'h0, 1'b0, 1'b0, POWER_MODE_RESET};
		end else if (start_evt) begin
			active_ctrl <= latched_q;
		end
	end
	assign power_status = st_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_strobe_one_clk: assert property (@(negedge serial_clk) disable iff (!link_rst_n)
		strobe_q |=> !strobe_q) else $error("strobe longer than one clock");
	a_launch_on_byte: assert property (@(negedge serial_clk) disable iff (!link_rst_n)
		byte_done_q |=> conv_q && out_cnt_q_n == 5'(RESULT_BITS)) else $error("no launch");
	a_result_count: assert property (@(negedge serial_clk) disable iff (!link_rst_n)
		strobe_q |-> conv_q [*8]) else $error("conversion ended early");
	a_trailing_zero: assert property (@(negedge serial_clk) disable iff (!link_rst_n)
		(out_cnt_q_n == 5'h0 && !byte_done_q) |=> !dout_q) else $error("nonzero tail");
	a_no_early_start: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
		(state_q == S_CONV && !overlap_ok) |=> state_q != S_CTRL)
		else $error("start taken before overlap point");
	a_idle_start: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
		(state_q == S_HUNT && !chip_select_n && serial_in) |=> state_q == S_CTRL)
		else $error("start bit missed");
	a_tristate_pins: assert property (@(posedge clk) disable iff (!reset_n)
		chip_select_n |-> !serial_out_oe && !conversion_strobe_oe)
		else $error("pins driven while deselected");
	a_full_power_conv: assert property (@(posedge clk) disable iff (!reset_n)
		st_q.converting |-> st_q.power_state == PM_NORMAL)
		else $error("low power during conversion");
	a_shutdown_stop: assert property (@(posedge clk) disable iff (!reset_n)
		!sd_n |=> !st_q.converting && st_q.hw_shutdown)
		else $error("shutdown did not stop");

	c_launch: cover property (@(negedge serial_clk) disable iff (!link_rst_n) byte_done_q);
	c_overlap: cover property (@(posedge serial_clk) disable iff (!link_rst_n)
		state_q == S_CONV ##1 state_q == S_CTRL);
	c_sleep: cover property (@(posedge clk) disable iff (!reset_n)
		done_evt ##1 st_q.power_state == PM_FULL_POWER_DOWN);
	c_shutdown: cover property (@(posedge clk) disable iff (!reset_n)
		st_q.converting ##1 !sd_n);
	c_wake: cover property (@(posedge clk) disable iff (!reset_n) $rose(st_q.powered_up));

	a_overlap_accept: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
		(state_q == S_CONV && overlap_ok && !chip_select_n && serial_in) |=> state_q == S_CTRL)
		else $error("start refused after overlap point");
	a_mode_applied: assert property (@(posedge clk) disable iff (!reset_n)
		(done_evt && !start_evt && sd_n) |=> st_q.power_state == pend_mode_q)
		else $error("programmed mode not entered");
	// Catches a release that would leave the block parked in a low-power state
	a_release_full: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(st_q.hw_shutdown) |-> st_q.power_state == PM_NORMAL)
		else $error("shutdown release not at full power");

endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ps

module host_model (
	output logic            serial_clk,
	output logic            chip_select_n,
	output logic            serial_in,
	input  wire logic       serial_out,
	input  wire logic       conversion_strobe
);
	logic [63:0] dout_cap;
	logic [63:0] strb_cap;

	// ----------------------------------------
	// Framing
	// ----------------------------------------
	initial begin
		serial_clk    = 1'b0;
		chip_select_n = 1'b1;
		serial_in     = 1'b0;
	end

	// Fixed 80 ns period; the slower clock advised in low-power modes is left out
	// No reference settling wait is modelled
	// Clock only runs inside a frame; data changes mid low phase
	task automatic run(input logic [63:0] din, input int n);
		#1;
		dout_cap      = '0;
		strb_cap      = '0;
		chip_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in = din[i];
			#20 serial_clk = 1'b1;
			dout_cap[i] = serial_out;
			strb_cap[i] = conversion_strobe;
			#40 serial_clk = 1'b0;
			#20;
		end
		chip_select_n = 1'b1;
		// Released line: show the inverse so a stale value is never trusted
		serial_in = ~serial_in;
	endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps

module testbench;
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0]  ctl;
		logic [11:0] smp;
	} row_t;

	logic                   clk;
	logic                   reset_n;
	logic                   hard_shutdown_n;
	logic [RESULT_BITS-1:0] sample_value;
	logic                   serial_clk;
	logic                   chip_select_n;
	logic                   serial_in;
	logic                   serial_out;
	logic                   serial_out_oe;
	logic                   conversion_strobe;
	logic                   conversion_strobe_oe;
	ctrl_byte_t             active_ctrl;
	power_status_t          power_status;
	int                     errors;
	int                     n_checks;
	int                     cycles;
	row_t                   rows [4] = '{'{8'hF3, 12'hA5C}, '{8'hAE, 12'h3F1},
	                                     '{8'hD5, 12'hFFF}, '{8'h88, 12'h001}};
	int                     offs [2] = '{14, 16};

	// ----------------------------------------
	// Harness
	// ----------------------------------------
	initial clk = 1'b0;
	always #2 clk = ~clk;

	adc_serial_framing_power_ctrl #(.WAKE_COUNT(5)) DUT (
		.clk(clk), .reset_n(reset_n), .serial_clk(serial_clk),
		.chip_select_n(chip_select_n), .serial_in(serial_in),
		.hard_shutdown_n(hard_shutdown_n), .sample_value(sample_value),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.conversion_strobe(conversion_strobe),
		.conversion_strobe_oe(conversion_strobe_oe),
		.active_ctrl(active_ctrl), .power_status(power_status));

	host_model host (
		.serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .conversion_strobe(conversion_strobe));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			close_out();
		end
	end

	task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [63:0] place(input logic [7:0] b, input int pos);
		place = '0;
		for (int k = 0; k < 8; k++) place[pos+k] = b[7-k];
	endfunction

	// Result MSB is sampled nine rising edges after the start bit
	function automatic logic [11:0] res(input int s);
		for (int k = 0; k < 12; k++) res[11-k] = host.dout_cap[s+9+k];
	endfunction

	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		cmp_word(64'(power_status.power_state), 64'(PM_NORMAL));
		cmp_word(64'(power_status.hw_shutdown), 64'h0);
		cmp_word(64'(conversion_strobe), 64'h0);
		cmp_word(64'(power_status.converting), 64'h0);
		// Host keeps quiet through the reset interval
		repeat (RESET_CYCLES) @(posedge clk);
		// Sixteen zeros, then a byte; the frame runs on until the result is out
		host.run(place(8'hF3, 16), 40);
		repeat (20) @(posedge clk);
		cmp_word(64'(host.dout_cap[24:0]), 64'h0);
		cmp_word(host.strb_cap, 64'h1 << 24);
		cmp_word(64'(res(16)), 64'(sample_value));
		$display("test reset done");
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		hard_shutdown_n = 1'b1;
		sample_value = 12'hA5C;
		do_reset();
		foreach (rows[r]) begin
			@(posedge clk) sample_value <= rows[r].smp;
			@(posedge clk);
			host.run(place(rows[r].ctl, 0), 24);
			repeat (20) @(posedge clk);
			cmp_word(host.strb_cap, 64'h100);
			cmp_word(64'(res(0)), 64'(rows[r].smp));
			cmp_word(64'(host.dout_cap[23:21]), 64'h0);
			cmp_word(64'(active_ctrl), 64'(rows[r].ctl[6:0]));
			cmp_word(64'(power_status.power_state), 64'(rows[r].ctl[1:0]));
			cmp_word(64'(power_status.converting), 64'h0);
			cmp_word(64'(power_status.powered_up), 64'(rows[r].ctl[1:0] != 2'h0));
			cmp_word(64'({serial_out_oe, conversion_strobe_oe}), 64'h0);
			$display("test row %0d done", r);
		end
		// Second frame at the earliest overlap point and at the 16-clock rate;
		// the first frame after the full power-down row is the wake-up conversion
		foreach (offs[i]) begin
			host.run(place(8'hF3, 0) | place(8'hF3, offs[i]), offs[i] + 24);
			repeat (20) @(posedge clk);
			cmp_word(host.strb_cap, (64'h1 << 8) | (64'h1 << (offs[i] + 8)));
			cmp_word(64'(res(offs[i])), 64'(sample_value));
			cmp_word(64'(power_status.powered_up), 64'h1);
			$display("test overlap %0d done", offs[i]);
		end
		// High bit before result bit 6 is out must not start anything
		host.run(place(8'hF3, 0) | (64'h1 << 10), 30);
		repeat (20) @(posedge clk);
		cmp_word(host.strb_cap, 64'h100);
		$display("test refused start done");
		// Shutdown in mid-result wipes the remaining bits
		@(posedge clk) sample_value <= 12'hFFF;
		fork
			host.run(place(8'hF3, 0), 24);
			begin
				repeat (300) @(posedge clk);
				cmp_word(64'({serial_out_oe, conversion_strobe_oe}), 64'h3);
				cmp_word(64'(power_status.converting), 64'h1);
				cmp_word(64'(power_status.power_state), 64'(PM_NORMAL));
				hard_shutdown_n <= 1'b0;
			end
		join
		repeat (20) @(posedge clk);
		cmp_word(64'(host.dout_cap[23:16]), 64'h0);
		cmp_word(64'(power_status.hw_shutdown), 64'h1);
		cmp_word(64'(power_status.converting), 64'h0);
		hard_shutdown_n <= 1'b1;
		host.run('0, 4);
		repeat (20) @(posedge clk);
		cmp_word(64'(power_status.hw_shutdown), 64'h0);
		cmp_word(64'(power_status.powered_up), 64'h1);
		cmp_word(64'(power_status.power_state), 64'(PM_NORMAL));
		$display("test shutdown done");
		do_reset();
		close_out();
	end
endmodule
